// File: bench/serial_lane_misc_control_asserts.sv
// concurrent checks on the ports of the lane misc control block
module serial_lane_misc_control_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        fast_overrange_flag,
  input wire logic        powerdown_pin_func,
  input wire logic        powerdown_pin,
  input wire logic        synth_restart,
  input wire logic [2:0]  lane_output_amplitude,
  input wire logic [9:0]  lane_swing_mv
);
  timeunit 1ns;
  timeprecision 1ps;
  // swing in mvpp for each amplitude code
  localparam logic [9:0] MV [8] = '{10'h35c, 10'h32a, 10'h302, 10'h2e9,
                                    10'h3c0, 10'h3a2, 10'h389, 10'h370};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************
  // properties
  // ****************************************
  sequence s_wr(a);
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == a;
  endsequence
  property p_reset_outs;
    disable iff (1'b0) !aresetn |=> !powerdown_pin && !synth_restart && !s_axi_bvalid
      && !s_axi_rvalid && lane_output_amplitude == 3'h0 && lane_swing_mv == 10'h35c;
  endproperty
  property p_swing;
    $stable(lane_output_amplitude) [*2] |-> lane_swing_mv == MV[lane_output_amplitude];
  endproperty
  property p_pin;
    fast_overrange_flag == powerdown_pin_func |=> powerdown_pin == $past(powerdown_pin_func);
  endproperty
  property p_restart;
    s_wr(8'h5c) ##0 s_axi_wstrb[0] |=> ##1 synth_restart == $past(s_axi_wdata[6], 2);
  endproperty
  property p_unmapped;
    s_wr(8'h40) |=> s_axi_bvalid && s_axi_bresp == 2'h2;
  endproperty
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_rdone;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  property p_rzero;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_reset_outs: assert property (p_reset_outs) else $error("outputs not cleared by reset");
  a_swing: assert property (p_swing) else $error("swing does not match code");
  a_pin: assert property (p_pin) else $error("pin differs from both sources");
  a_restart: assert property (p_restart) else $error("restart output wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped write not refused");
  a_bdone: assert property (p_bdone) else $error("write response repeated");
  a_rdone: assert property (p_rdone) else $error("read response repeated");
  a_rzero: assert property (p_rzero) else $error("upper read bits set");
endmodule // serial_lane_misc_control_asserts

bind serial_lane_misc_control serial_lane_misc_control_asserts i_serial_lane_misc_control_asserts (
  .aclk                  (aclk),
  .aresetn               (aresetn),
  .s_axi_awaddr          (s_axi_awaddr),
  .s_axi_awvalid         (s_axi_awvalid),
  .s_axi_awready         (s_axi_awready),
  .s_axi_wdata           (s_axi_wdata),
  .s_axi_wstrb           (s_axi_wstrb),
  .s_axi_wvalid          (s_axi_wvalid),
  .s_axi_wready          (s_axi_wready),
  .s_axi_bresp           (s_axi_bresp),
  .s_axi_bvalid          (s_axi_bvalid),
  .s_axi_bready          (s_axi_bready),
  .s_axi_rdata           (s_axi_rdata),
  .s_axi_rvalid          (s_axi_rvalid),
  .s_axi_rready          (s_axi_rready),
  .fast_overrange_flag   (fast_overrange_flag),
  .powerdown_pin_func    (powerdown_pin_func),
  .powerdown_pin         (powerdown_pin),
  .synth_restart         (synth_restart),
  .lane_output_amplitude (lane_output_amplitude),
  .lane_swing_mv         (lane_swing_mv)
);

// File: bench/tb_top.sv
// self-checking bench for the lane misc control registers
`include "lane_misc_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        fast_overrange_flag = 1'b0, powerdown_pin_func = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, lane_output_amplitude;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h7a24;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        powerdown_pin, synth_restart;
  logic [9:0]  lane_swing_mv;
  int          fail_count = 0, n_tests = 0, mdl[4];
  localparam logic [7:0] ADR [3] = '{8'h5c, 8'h68, 8'h6c};
  localparam logic [7:0] MSK [3] = '{`MASK_SYNTH_RESET_CONTROL, `MASK_OVERRANGE_ROUTE_CONTROL,
                                     `MASK_AMPLITUDE_OVERRIDE_CONTROL};
  localparam logic [9:0] MV [8] = '{10'h35c, 10'h32a, 10'h302, 10'h2e9,
                                    10'h3c0, 10'h3a2, 10'h389, 10'h370};

  // block under test
  serial_lane_misc_control i_serial_lane_misc_control (
    .aclk                  (aclk),
    .aresetn               (aresetn),
    .s_axi_awaddr          (s_axi_awaddr),
    .s_axi_awprot          (s_axi_awprot),
    .s_axi_awvalid         (s_axi_awvalid),
    .s_axi_awready         (s_axi_awready),
    .s_axi_wdata           (s_axi_wdata),
    .s_axi_wstrb           (s_axi_wstrb),
    .s_axi_wvalid          (s_axi_wvalid),
    .s_axi_wready          (s_axi_wready),
    .s_axi_bresp           (s_axi_bresp),
    .s_axi_bvalid          (s_axi_bvalid),
    .s_axi_bready          (s_axi_bready),
    .s_axi_araddr          (s_axi_araddr),
    .s_axi_arprot          (s_axi_arprot),
    .s_axi_arvalid         (s_axi_arvalid),
    .s_axi_arready         (s_axi_arready),
    .s_axi_rdata           (s_axi_rdata),
    .s_axi_rresp           (s_axi_rresp),
    .s_axi_rvalid          (s_axi_rvalid),
    .s_axi_rready          (s_axi_rready),
    .fast_overrange_flag   (fast_overrange_flag),
    .powerdown_pin_func    (powerdown_pin_func),
    .powerdown_pin         (powerdown_pin),
    .synth_restart         (synth_restart),
    .lane_output_amplitude (lane_output_amplitude),
    .lane_swing_mv         (lane_swing_mv)
  );

  // clock of 25 ns period
  always #12.5 aclk = ~aclk;

  // ****************************************
  // helpers
  // ****************************************
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function int find(input logic [7:0] a);
    for (int k = 0; k < 3; k++) if (ADR[k] == a) return k;
    return 3;
  endfunction

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one write, both channels offered together, model updated
  task wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    i = find(a);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    if (i < 3 && s_axi_wstrb[0]) mdl[i] = d[7:0] & MSK[i];
    chk("bresp", (i < 3) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR, s_axi_bresp);
  endtask

  // one read compared with the model
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", mdl[find(a)], s_axi_rdata);
    chk("rresp", (find(a) < 3) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR, s_axi_rresp);
  endtask

  // settled register-driven outputs
  task outs();
    repeat (3) @(posedge aclk);
    chk("synth_restart", mdl[0][6], synth_restart);
    chk("lane_output_amplitude", mdl[2][7:5], lane_output_amplitude);
    chk("lane_swing_mv", MV[mdl[2][7:5]], lane_swing_mv);
  endtask

  // random pin sources, pin checked one edge later
  task pins();
    logic [31:0] r;
    repeat (8) begin
      r = rnd();
      @(posedge aclk);
      fast_overrange_flag <= r[0];
      powerdown_pin_func <= r[1];
      @(posedge aclk);
      @(negedge aclk);
      chk("powerdown_pin", (mdl[1][1] & mdl[2][3]) ? r[0] : r[1], powerdown_pin);
    end
  endtask

  task final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    final_report();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (ADR[k]) rd(ADR[k]);
    outs();
    $display("reset values done");
    foreach (ADR[k]) begin
      wr(ADR[k], rnd() & MSK[k]);
      rd(ADR[k]);
    end
    s_axi_wstrb <= 4'he;
    wr(8'h6c, ~mdl[2] & 32'he8);
    rd(8'h6c);
    s_axi_wstrb <= 4'hf;
    wr(8'h40, rnd());
    rd(8'h40);
    $display("masks and unmapped done");
    for (int c = 0; c < 8; c++) begin
      wr(8'h6c, (rnd() & 32'h08) | (c << 5));
      outs();
    end
    $display("amplitude codes done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h68, m[0] ? 32'h02 : 32'h00);
      wr(8'h6c, m[1] ? 32'h08 : 32'h00);
      pins();
    end
    $display("pin routing done");
    wr(8'h5c, 32'h40);
    outs();
    wr(8'h5c, 32'h0);
    outs();
    $display("restart pulse done");
    wr(8'h6c, 32'he8);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (mdl[k]) mdl[k] = 0;
    foreach (ADR[k]) rd(ADR[k]);
    outs();
    $display("mid-run reset done");
    final_report();
  end
endmodule // tb_top

// File: verilog/lane_misc_byte_reg.sv
// one byte-wide configuration register with a writable-bit mask
`include "lane_misc_consts.svh"

module lane_misc_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK  = 8'hff
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] value_r
);

  timeunit 1ns;
  timeprecision 1ps;

  // unassigned bits never take a one, whatever software writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_r <= RESET_VALUE;
    end else if (wr_en) begin
      value_r <= wr_data & WRITE_MASK;
    end
  end

endmodule // lane_misc_byte_reg

// File: verilog/lane_misc_consts.svh
// register offsets, field positions, reset values and code tables for the lane misc group
`ifndef LANE_MISC_CONSTS_SVH
`define LANE_MISC_CONSTS_SVH

// register indices: the byte address on the bus is the index times four
`define IDX_SYNTH_RESET_CONTROL       8'h17
`define IDX_OVERRANGE_ROUTE_CONTROL   8'h1a
`define IDX_AMPLITUDE_OVERRIDE_CONTROL 8'h1b
`define REG_WORD_SHIFT                2

// field positions
`define SYNTH_RESTART_BIT             6
`define OVERRANGE_ROUTE_A_BIT         1
`define OVERRIDE_ENABLE_BIT           3
`define AMPLITUDE_MSB                 7
`define AMPLITUDE_LSB                 5

// reset values
`define RST_SYNTH_RESET_CONTROL       8'h00
`define RST_OVERRANGE_ROUTE_CONTROL   8'h00
`define RST_AMPLITUDE_OVERRIDE_CONTROL 8'h00

// writable masks: unassigned bits are held at zero
`define MASK_SYNTH_RESET_CONTROL      8'h40
`define MASK_OVERRANGE_ROUTE_CONTROL  8'h02
`define MASK_AMPLITUDE_OVERRIDE_CONTROL 8'he8

// swing in mVpp for each amplitude code
`define SWING_MV_0 10'h35c
`define SWING_MV_1 10'h32a
`define SWING_MV_2 10'h302
`define SWING_MV_3 10'h2e9
`define SWING_MV_4 10'h3c0
`define SWING_MV_5 10'h3a2
`define SWING_MV_6 10'h389
`define SWING_MV_7 10'h370

// axi response codes
`define AXI_RESP_OKAY   2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// File: verilog/lane_misc_pkg.sv
// types shared by the lane misc control block
package lane_misc_pkg;

  timeunit 1ns;
  timeprecision 1ps;

  // three configuration bytes held by the block
  typedef struct packed {
    logic [7:0] synth_reset_control;
    logic [7:0] overrange_route_control;
    logic [7:0] amplitude_override_control;
  } lane_misc_regs_t;

  // decoded register select
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_SYNTH,
    SEL_ROUTE,
    SEL_AMPL
  } reg_sel_t;

  // pin mux result
  typedef struct packed {
    logic pin_value;
    logic pin_overridden;
  } pin_route_t;

endpackage

// File: verilog/lane_misc_swing_lut.sv
// lookup of the transmit swing in mVpp, held in a register
`include "lane_misc_consts.svh"

module lane_misc_swing_lut (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] code,
  output logic      [9:0] swing_mv_r
);

  timeunit 1ns;
  timeprecision 1ps;

  logic [9:0] swing_nxt;

  // code to swing table
  always_comb begin
    case (code)
      3'h0:    swing_nxt = `SWING_MV_0;
      3'h1:    swing_nxt = `SWING_MV_1;
      3'h2:    swing_nxt = `SWING_MV_2;
      3'h3:    swing_nxt = `SWING_MV_3;
      3'h4:    swing_nxt = `SWING_MV_4;
      3'h5:    swing_nxt = `SWING_MV_5;
      3'h6:    swing_nxt = `SWING_MV_6;
      default: swing_nxt = `SWING_MV_7;
    endcase
  end

  // registered swing output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      swing_mv_r <= `SWING_MV_0;
    end else begin
      swing_mv_r <= swing_nxt;
    end
  end

endmodule // lane_misc_swing_lut

// File: verilog/serial_lane_misc_control.sv
// serial lane misc control registers with axi4-lite slave and pin routing
//
// Notes on behaviour
// - the synthesizer restart bit (bit 6 of the reset byte) resets to zero and software pulses it 0-1-0 once after power-up.
// - with the route bit (bit 1) set, channel A fast overrange drives the power-down pin, else the pin is normal.
// - the route bit only acts while the override enable (bit 3 of the amplitude byte) is set.
// - with the override enable and the route bit both set the pin carries channel A overrange, otherwise the pin keeps its function.
// - amplitude bits 7 to 5 pick lane swing 860, 810, 770, 745, 960, 930, 905 or 880 mVpp.
// - the hardware reset returns every register of the group to its default.
//
// write side: awready and wready fall on the edge that takes their half and rise again
// on the edge that accepts the response; bvalid rises on the edge that takes the last of the two halves,
// on the same edge that the register byte changes.
// read side: rvalid rises on the edge that takes the address, and arready stays low until
// the edge after the read data have been accepted, so reads are separated by an idle cycle.
// unmapped addresses answer with a slave error, store nothing and read back as zero.
// only byte lane 0 carries register data; with strobe bit 0 clear a write stores nothing.
// the restart bit is plain storage: software makes the 0-1-0 pulse with two writes.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`include "lane_misc_consts.svh"

module serial_lane_misc_control
  import lane_misc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // device side
  input  wire logic        fast_overrange_flag,
  input  wire logic        powerdown_pin_func,
  output logic             powerdown_pin,
  output logic             synth_restart,
  output logic [2:0]       lane_output_amplitude,
  output logic [9:0]       lane_swing_mv
);

  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // write channel
  // ************************************************************

  // address and data may arrive in either order; the first to come is held until its
  // partner arrives, and the store happens on the edge at which both are present

  logic [7:0]  aw_addr_r;
  logic        aw_held_r;
  logic [31:0] w_data_r;
  logic        w_strb0_r;
  logic        w_held_r;
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;

  wire aw_take   = s_axi_awvalid && awready_r;
  wire w_take    = s_axi_wvalid && wready_r;
  wire aw_have   = aw_held_r || aw_take;
  wire w_have    = w_held_r || w_take;
  wire wr_fire   = aw_have && w_have && !bvalid_r;
  wire [7:0] wr_addr_cur = aw_take ? s_axi_awaddr : aw_addr_r;
  wire [7:0] wr_data_cur = w_take ? s_axi_wdata[7:0] : w_data_r[7:0];
  wire       wr_strb_cur = w_take ? s_axi_wstrb[0] : w_strb0_r;

  // address decode of the write side, byte address is index times four
  wire [7:0] wr_word = wr_addr_cur >> `REG_WORD_SHIFT;
  wire hit_wr_synth = (wr_word == `IDX_SYNTH_RESET_CONTROL);
  wire hit_wr_route = (wr_word == `IDX_OVERRANGE_ROUTE_CONTROL);
  wire hit_wr_ampl  = (wr_word == `IDX_AMPLITUDE_OVERRIDE_CONTROL);
  wire wr_mapped    = hit_wr_synth || hit_wr_route || hit_wr_ampl;
  wire wr_byte_ok   = wr_fire && wr_strb_cur;

  wire wr_en_synth = wr_byte_ok && hit_wr_synth;
  wire wr_en_route = wr_byte_ok && hit_wr_route;
  wire wr_en_ampl  = wr_byte_ok && hit_wr_ampl;

  // hold address and data until both have arrived
  // a pending response blocks the store, so a second write never overwrites the first answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb0_r <= 1'b0;
    end else begin
      if (aw_take) aw_addr_r <= s_axi_awaddr;
      if (w_take) w_data_r <= s_axi_wdata;
      if (w_take) w_strb0_r <= s_axi_wstrb[0];
      aw_held_r <= aw_have && !wr_fire;
      w_held_r  <= w_have && !wr_fire;
    end
  end

  // a half that waits, or an answer not yet taken, keeps its ready low
  wire aw_waiting    = aw_have && !wr_fire;
  wire w_waiting     = w_have && !wr_fire;
  wire b_stalled     = bvalid_r && !s_axi_bready;
  wire awready_nxt   = !aw_waiting && !b_stalled && !wr_fire;
  wire wready_nxt    = !w_waiting && !b_stalled && !wr_fire;
  wire [1:0] wr_resp = wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;

  // ready stays low while one half waits or a response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
    end else begin
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
    end
  end

  // write response one cycle after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `AXI_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_resp;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ************************************************************
  // register bank
  // ************************************************************

  // each byte keeps only its assigned bits; the others are cleared on every write so
  // that a read never shows a one in a position that software must keep at zero
  lane_misc_regs_t regs;

  // restart bit: software drives the 0-1-0 pulse, hardware only holds it
  lane_misc_byte_reg #(
    .RESET_VALUE (`RST_SYNTH_RESET_CONTROL),
    .WRITE_MASK  (`MASK_SYNTH_RESET_CONTROL)
  ) u_synth_reg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_en_synth),
    .wr_data (wr_data_cur),
    .value_r (regs.synth_reset_control)
  );

  // route byte: only the channel A route bit is kept
  lane_misc_byte_reg #(
    .RESET_VALUE (`RST_OVERRANGE_ROUTE_CONTROL),
    .WRITE_MASK  (`MASK_OVERRANGE_ROUTE_CONTROL)
  ) u_route_reg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_en_route),
    .wr_data (wr_data_cur),
    .value_r (regs.overrange_route_control)
  );

  // amplitude byte: swing code and pin override enable
  lane_misc_byte_reg #(
    .RESET_VALUE (`RST_AMPLITUDE_OVERRIDE_CONTROL),
    .WRITE_MASK  (`MASK_AMPLITUDE_OVERRIDE_CONTROL)
  ) u_ampl_reg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_en_ampl),
    .wr_data (wr_data_cur),
    .value_r (regs.amplitude_override_control)
  );

  // ************************************************************
  // pin routing and lane amplitude
  // ************************************************************

  // the pin and the lane controls are registered once more so that every output of
  // the block leaves a flip-flop; each follows its register bit one edge later

  wire route_a_bit  = regs.overrange_route_control[`OVERRANGE_ROUTE_A_BIT];
  wire override_bit = regs.amplitude_override_control[`OVERRIDE_ENABLE_BIT];
  wire [2:0] ampl_code =
    regs.amplitude_override_control[`AMPLITUDE_MSB:`AMPLITUDE_LSB];

  // the route bit alone does nothing: both bits must be set before the pin is taken over
  wire route_active = override_bit && route_a_bit;

  pin_route_t pin_route;
  assign pin_route.pin_overridden = route_active;
  assign pin_route.pin_value = route_active ?
                               fast_overrange_flag : powerdown_pin_func;

  logic       powerdown_pin_r;
  logic       synth_restart_r;
  logic [2:0] amplitude_r;

  // registered outputs toward the pin and the lane transmitters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powerdown_pin_r <= 1'b0;
      synth_restart_r <= 1'b0;
      amplitude_r     <= 3'h0;
    end else begin
      powerdown_pin_r <= pin_route.pin_value;
      synth_restart_r <= regs.synth_reset_control[`SYNTH_RESTART_BIT];
      amplitude_r     <= ampl_code;
    end
  end

  // swing lookup, registered inside so that it lines up with the amplitude output
  lane_misc_swing_lut u_swing (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .code       (ampl_code),
    .swing_mv_r (lane_swing_mv)
  );

  // ************************************************************
  // read channel
  // ************************************************************

  // the read address is decoded straight from the bus; the data word is captured on
  // the taking edge and stands unchanged until the master accepts it

  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  wire ar_take = s_axi_arvalid && arready_r;
  wire [7:0] rd_word = s_axi_araddr >> `REG_WORD_SHIFT;
  wire hit_rd_synth = (rd_word == `IDX_SYNTH_RESET_CONTROL);
  wire hit_rd_route = (rd_word == `IDX_OVERRANGE_ROUTE_CONTROL);
  wire hit_rd_ampl  = (rd_word == `IDX_AMPLITUDE_OVERRIDE_CONTROL);
  wire rd_mapped    = hit_rd_synth || hit_rd_route || hit_rd_ampl;

  // read select, upper bits read as zero
  wire [7:0] rd_byte = hit_rd_synth ? regs.synth_reset_control :
                       hit_rd_route ? regs.overrange_route_control :
                       hit_rd_ampl  ? regs.amplitude_override_control : 8'h00;

  // read word and response for the taking edge
  wire [31:0] rd_word_data = {24'h00_0000, rd_byte};
  wire [1:0]  rd_resp      = rd_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;

  // one read at a time; ready drops while data waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `AXI_RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_word_data;
      rresp_r   <= rd_resp;
    end else if (rvalid_r) begin
      if (s_axi_rready) rvalid_r <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      arready_r <= 1'b1;
    end
  end

  // ************************************************************
  // output connections
  // ************************************************************

  // every port below is a plain copy of a register
  assign s_axi_awready         = awready_r;
  assign s_axi_wready          = wready_r;
  assign s_axi_bvalid          = bvalid_r;
  assign s_axi_bresp           = bresp_r;
  assign s_axi_arready         = arready_r;
  assign s_axi_rvalid          = rvalid_r;
  assign s_axi_rdata           = rdata_r;
  assign s_axi_rresp           = rresp_r;
  assign powerdown_pin         = powerdown_pin_r;
  assign synth_restart         = synth_restart_r;
  assign lane_output_amplitude = amplitude_r;

endmodule // serial_lane_misc_control
